/* ilcg_pkg.sv */
// Package: constants and carrier types for the lane alignment octet block
package ilcg_pkg;
  localparam int SAMPLE_WIDTH = 14;
  localparam int LATENCY_CYCLES = 20;
  localparam int CFG_OCTETS = 14;
  localparam logic [3:0] LAST_OCTET = 4'hd;
  localparam logic [4:0] FRAME_COUNT_ONE_LANE = 5'h08;
  localparam logic [4:0] FRAME_COUNT_TWO_LANE = 5'h10;
  localparam logic [4:0] SAMPLE_RES_FIELD = 5'h0d;
  localparam logic [4:0] TOTAL_BITS_FIELD = 5'h0f;
  localparam logic [7:0] FRAME_OCTETS_ONE_LANE = 8'h01;
  localparam logic [7:0] FRAME_OCTETS_TWO_LANE = 8'h00;
  localparam logic [4:0] LANE_FIELD_TWO_LANE = 5'h01;
  localparam logic [SAMPLE_WIDTH-1:0] SIGN_FLIP = 14'h2000;

  // Static settings steering the octet generator
  typedef struct packed {
    logic alignEnable;
    logic oneLane;
    logic scramblerSelect;
    logic frameCountOverride;
    logic [4:0] programmedFrameCount;
    logic twosComplement;
  } ilcg_cfg_t;

  // One configuration octet on the link
  typedef struct packed {
    logic valid;
    logic last;
    logic [3:0] index;
    logic [7:0] data;
  } ilcg_octet_t;
endpackage

/* ilcg_generator.sv */
// Module: alignment octet generator with sample pipeline and coding
`timescale 1ns/1ps
// What this block does
// - No alignment sequence after reset; sent only when enabled.
// - Alignment sends configuration octets 0 to 13, layout per lane mode.
// - Frame count defaults 01000 one-lane, 10000 two-lane; override wins.
// - Octets 11 and 12 are reserved and sent as zero.
// - Conversion starts and input is sampled on the rising clock edge.
// - Each sample leaves exactly 20 clock cycles after capture.
// - Output samples are 14 bits, offset binary or two's complement.
module ilcg_generator #(
  parameter int LATENCY = ilcg_pkg::LATENCY_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire ilcg_pkg::ilcg_cfg_t cfg,
  input wire logic laneSel,
  input wire logic alignStart,
  input wire logic [ilcg_pkg::SAMPLE_WIDTH-1:0] sampleIn,
  output ilcg_pkg::ilcg_octet_t octetOut,
  output logic alignBusy,
  output logic [ilcg_pkg::SAMPLE_WIDTH-1:0] sampleOut
);
  // ==========================================================
  // Configuration field table
  // Pure function of settings, so octet content never depends on history
  function automatic logic [7:0] cfgOctet(input logic [3:0] idx,
      input ilcg_pkg::ilcg_cfg_t c, input logic lane);
    logic [4:0] k;
    begin
      k = c.oneLane ? ilcg_pkg::FRAME_COUNT_ONE_LANE
                    : ilcg_pkg::FRAME_COUNT_TWO_LANE;
      if (c.frameCountOverride) begin
        k = c.programmedFrameCount;
      end
      unique case (idx)
        4'h2: cfgOctet = {3'h0, 4'h0, c.oneLane ? 1'b0 : lane};
        4'h3: cfgOctet = {c.scramblerSelect, 2'h0,
                c.oneLane ? 5'h00 : ilcg_pkg::LANE_FIELD_TWO_LANE};
        4'h4: cfgOctet = c.oneLane ? ilcg_pkg::FRAME_OCTETS_ONE_LANE
                                   : ilcg_pkg::FRAME_OCTETS_TWO_LANE;
        4'h5: cfgOctet = {3'h0, k};
        4'h7: cfgOctet = {3'h0, ilcg_pkg::SAMPLE_RES_FIELD};
        4'h8: cfgOctet = {3'h0, ilcg_pkg::TOTAL_BITS_FIELD};
        default: cfgOctet = 8'h00; // Octets 0,1,6,9,10,11,12
      endcase
    end
  endfunction

  // Checksum sums field values: octet sum, less the scrambler bit's weight
  function automatic logic [7:0] cfgSum(input ilcg_pkg::ilcg_cfg_t c,
      input logic lane);
    logic [7:0] s;
    begin
      s = 8'h00;
      for (int i = 0; i < ilcg_pkg::CFG_OCTETS - 1; i++) begin
        s = s + cfgOctet(4'(i), c, lane);
      end
      // Scrambler field counts as one, not as its octet weight of 128
      s = s - {c.scramblerSelect, 7'h00} + {7'h00, c.scramblerSelect};
      cfgSum = s;
    end
  endfunction

  // ==========================================================
  // Alignment sequencer
  typedef enum logic {ILCG_IDLE, ILCG_SEND} ilcg_state_t;
  ilcg_state_t stateQ, stateD;
  logic [3:0] idxQ, idxD;
  ilcg_pkg::ilcg_octet_t octetQ, octetD;

  // Next state; start is ignored while a sequence is running
  always_comb begin
    stateD = stateQ;
    idxD = idxQ;
    octetD = '0;
    unique case (stateQ)
      ILCG_IDLE: begin
        if (alignStart && cfg.alignEnable) begin
          stateD = ILCG_SEND;
          idxD = 4'h0;
        end
      end
      ILCG_SEND: begin
        octetD.valid = 1'b1;
        octetD.index = idxQ;
        octetD.last = (idxQ == ilcg_pkg::LAST_OCTET);
        octetD.data = octetD.last ? cfgSum(cfg, laneSel)
                                  : cfgOctet(idxQ, cfg, laneSel);
        if (idxQ == ilcg_pkg::LAST_OCTET) begin
          stateD = ILCG_IDLE;
        end
        idxD = idxQ + 4'h1;
      end
    endcase
  end

  // Reset leaves the sequence off until enabled and requested
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateQ <= ILCG_IDLE;
      idxQ <= 4'h0;
      octetQ <= '0;
    end else begin
      stateQ <= stateD;
      idxQ <= idxD;
      octetQ <= octetD;
    end
  end

  assign octetOut = octetQ;
  assign alignBusy = octetQ.valid;

  // ==========================================================
  // Sample pipeline: capture stage plus LATENCY-1 further stages
  logic [ilcg_pkg::SAMPLE_WIDTH-1:0] pipeQ [LATENCY];
  logic [ilcg_pkg::SAMPLE_WIDTH-1:0] pipeD [LATENCY];

  // Coding applied at capture; top bit flip maps offset to two's complement
  always_comb begin
    pipeD[0] = cfg.twosComplement ? (sampleIn ^ ilcg_pkg::SIGN_FLIP)
                                  : sampleIn;
    for (int i = 1; i < LATENCY; i++) begin
      pipeD[i] = pipeQ[i-1];
    end
  end

  // One stage per rising edge; no reset needed on the datapath
  always_ff @(posedge core_clk) begin
    for (int i = 0; i < LATENCY; i++) begin
      pipeQ[i] <= pipeD[i];
    end
  end

  assign sampleOut = pipeQ[LATENCY-1];

  // ==========================================================
  // Assertion helper: edges since the coding setting was last set
  // A counter stands in for a long repetition the tools would unroll
  logic [7:0] offCntQ, offCntD;

  // Saturates so a long run cannot wrap back below the threshold
  always_comb begin
    offCntD = offCntQ;
    if (cfg.twosComplement) begin
      offCntD = 8'h00;
    end else if (offCntQ != 8'hff) begin
      offCntD = offCntQ + 8'h01;
    end
  end

  // Reset clears the count so the unreset pipeline refills first
  always_ff @(posedge core_clk) begin
    if (rst) begin
      offCntQ <= 8'h00;
    end else begin
      offCntQ <= offCntD;
    end
  end

  // ==========================================================
  // Assertions
  property p_noAlignWhenOff;
    @(posedge core_clk) disable iff (rst)
      !cfg.alignEnable && stateQ == ILCG_IDLE
        |=> stateQ == ILCG_IDLE && !octetQ.valid;
  endproperty
  a_noAlignWhenOff: assert property (p_noAlignWhenOff)
    else $error("alignment octet sent while disabled");

  property p_fourteenOctets;
    @(posedge core_clk) disable iff (rst)
      $rose(octetQ.valid) |-> octetQ.index == 4'h0 ##13 octetQ.last ##1
        !octetQ.valid;
  endproperty
  a_fourteenOctets: assert property (p_fourteenOctets)
    else $error("alignment sequence not 14 octets");

  property p_frameCount;
    @(posedge core_clk) disable iff (rst)
      octetQ.valid && octetQ.index == 4'h5 && !$past(cfg.frameCountOverride)
      && $stable(cfg) |-> octetQ.data[4:0] == ($past(cfg.oneLane) ?
        ilcg_pkg::FRAME_COUNT_ONE_LANE : ilcg_pkg::FRAME_COUNT_TWO_LANE);
  endproperty
  a_frameCount: assert property (p_frameCount)
    else $error("frame count default wrong");

  property p_reservedZero;
    @(posedge core_clk) disable iff (rst)
      octetQ.valid && (octetQ.index == 4'hb || octetQ.index == 4'hc)
        |-> octetQ.data == 8'h00;
  endproperty
  a_reservedZero: assert property (p_reservedZero)
    else $error("reserved octet not zero");

  property p_latency;
    @(posedge core_clk) disable iff (rst)
      offCntQ >= 8'(LATENCY) |-> sampleOut == $past(sampleIn, LATENCY);
  endproperty
  a_latency: assert property (p_latency)
    else $error("sample latency not 20 cycles");

  property p_coding;
    @(posedge core_clk) disable iff (rst)
      cfg.twosComplement |=> pipeQ[0] == ($past(sampleIn) ^
        ilcg_pkg::SIGN_FLIP);
  endproperty
  a_coding: assert property (p_coding)
    else $error("two's complement coding wrong");

  property p_offsetCoding;
    @(posedge core_clk) disable iff (rst)
      !cfg.twosComplement |=> pipeQ[0] == $past(sampleIn);
  endproperty
  a_offsetCoding: assert property (p_offsetCoding)
    else $error("offset binary coding altered sample");

  property p_checksum;
    @(posedge core_clk) disable iff (rst)
      octetQ.valid && octetQ.last && $stable(cfg) && $stable(laneSel)
        |-> octetQ.data == cfgSum(cfg, laneSel);
  endproperty
  a_checksum: assert property (p_checksum)
    else $error("checksum octet wrong");

  property p_startTaken;
    @(posedge core_clk) disable iff (rst)
      stateQ == ILCG_IDLE && alignStart && cfg.alignEnable
        |-> ##2 octetQ.valid && octetQ.index == 4'h0;
  endproperty
  a_startTaken: assert property (p_startTaken)
    else $error("alignment start not honoured");

  c_oneLane: cover property (@(posedge core_clk) disable iff (rst)
    octetQ.last && cfg.oneLane);
  c_twoLane: cover property (@(posedge core_clk) disable iff (rst)
    octetQ.last && !cfg.oneLane && laneSel);
  c_override: cover property (@(posedge core_clk) disable iff (rst)
    octetQ.valid && octetQ.index == 4'h5 && cfg.frameCountOverride);
endmodule

/* ilcg_rx_model.sv */
// Receiver model that counts configuration octets seen on the link
`timescale 1ns/1ps
// ==========
// Receiver
module ilcg_rx_model (
  input wire logic core_clk,
  input wire ilcg_pkg::ilcg_octet_t octetIn,
  output int rxCount
);
  // Restart on octet 0 so each sequence is counted alone
  always_ff @(posedge core_clk) begin
    if (octetIn.valid && octetIn.index == 4'h0) begin
      rxCount <= 1;
    end else if (octetIn.valid) begin
      rxCount <= rxCount + 1;
    end
  end
endmodule

/* testbench.sv */
// Self-checking bench for the alignment octet generator
`timescale 1ns/1ps
// ==========
// Bench
module testbench;
  typedef struct packed {
    logic one, scr, ovr;
    logic [4:0] prog;
    logic lane;
    logic [4:0] k;
  } ilcg_row_t;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  ilcg_pkg::ilcg_cfg_t cfg = '0;
  logic laneSel = 1'b0;
  logic alignStart = 1'b0;
  logic [13:0] sampleIn = 14'h0000;
  ilcg_pkg::ilcg_octet_t octetOut;
  logic alignBusy;
  logic [13:0] sampleOut;
  logic [13:0] hist [0:63];
  int rxCount;
  int bad_count = 0;
  int n_compared = 0;
  // Rows: lane mode, scrambler, override, programmed, lane, expected count
  ilcg_row_t rows [4] = '{'{1'b1, 1'b0, 1'b0, 5'h00, 1'b0, 5'h08},
    '{1'b0, 1'b1, 1'b0, 5'h03, 1'b0, 5'h10},
    '{1'b0, 1'b0, 1'b1, 5'h1f, 1'b1, 5'h1f},
    '{1'b1, 1'b1, 1'b1, 5'h00, 1'b0, 5'h00}};

  always #4 core_clk = ~core_clk;

  ilcg_generator dut (.core_clk(core_clk), .rst(rst), .cfg(cfg),
    .laneSel(laneSel), .alignStart(alignStart), .sampleIn(sampleIn),
    .octetOut(octetOut), .alignBusy(alignBusy), .sampleOut(sampleOut));
  ilcg_rx_model rx (.core_clk(core_clk), .octetIn(octetOut),
    .rxCount(rxCount));

  // ==========
  // Helpers
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic summarize;
    if (bad_count == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Checksum is a field sum, so the scrambler bit counts as one
  function automatic logic [7:0] expOct(ilcg_row_t r, int i);
    case (i)
      2: return {7'h00, r.lane & ~r.one};
      3: return {r.scr, 6'h00, ~r.one};
      4: return {7'h00, r.one};
      5: return {3'h0, r.k};
      7: return 8'h0d;
      8: return 8'h0f;
      13: return {7'h00, r.scr} + {3'h0, r.k} + 8'h1d
        + {7'h00, r.lane & ~r.one};
      default: return 8'h00;
    endcase
  endfunction

  // One start pulse, then the whole sequence octet by octet
  task automatic runSeq(ilcg_row_t r);
    int w;
    logic [15:0] e;
    cfg = {1'b1, r.one, r.scr, r.ovr, r.prog, 1'b0};
    laneSel = r.lane;
    alignStart = 1'b1;
    @(negedge core_clk);
    alignStart = 1'b0;
    for (w = 1; w < 9 && octetOut.valid !== 1'b1; w++) @(negedge core_clk);
    chk("delay", 16'h0002, 16'(w));
    if (w == 9) summarize();
    for (int i = 0; i < 14; i++) begin
      e = 16'({1'b1, i == 13, 4'(i), expOct(r, i)});
      chk("octet", e, 16'(octetOut));
      chk("busy", 16'h0001, 16'(alignBusy));
      @(negedge core_clk);
    end
    chk("count", 16'h000e, 16'(rxCount));
    chk("idle", 16'h0000, 16'(alignBusy));
  endtask

  // ==========
  // Main sequence
  initial begin
    repeat (16) @(negedge core_clk);
    rst = 1'b0;
    chk("rstOct", 16'h0000, 16'(octetOut));
    // Start requested while the sequence is disabled
    alignStart = 1'b1;
    repeat (20) begin
      @(negedge core_clk);
      chk("off", 16'h0000, 16'(alignBusy));
    end
    alignStart = 1'b0;
    foreach (rows[j]) runSeq(rows[j]);
    // Coding flips halfway to catch a stale capture stage
    for (int n = 0; n < 64; n++) begin
      if (n >= 20) begin
        chk("sample", 16'(hist[n-20]), 16'(sampleOut));
      end
      sampleIn = {n[3], 13'(n * 37)};
      cfg.twosComplement = n[5];
      hist[n] = sampleIn ^ (n[5] ? ilcg_pkg::SIGN_FLIP : 14'h0000);
      @(negedge core_clk);
    end
    summarize();
  end
endmodule
